/* File: core/adcpd_ctrl.sv */
// Overview of operation
// - Power-down pin high shuts analog and reference
// - Unread result stays shiftable during power-down
// - Host convert pulses; device answers as master or slave per select
// - Select low: device drives serial clock
// - Select high: serial clock taken from outside
`timescale 1ns/10ps
`include "adcpd_params.svh"

module adcpd_ctrl
   import adcpd_pkg::*;
#(
   parameter int unsigned RECOVERY_CYCLES = `ADCPD_RECOVERY_CYCLES
)
(
   input  wire logic                        i_clock,
   input  wire logic                        i_reset,
   input  wire logic                        i_clk_en,
   input  wire logic                        i_power_down_pin,
   input  wire logic                        i_clock_source_select,
   input  wire logic                        i_cs_n,
   input  wire logic                        i_convert_n,
   input  wire logic                        i_ext_sclk,
   input  wire logic [`ADCPD_RESULT_W-1:0]  i_sample_data,
   output logic                             o_busy_n,
   output logic                             o_data,
   output logic                             o_data_clk,
   output logic                             o_analog_on,
   output logic                             o_ref_settled
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   adcpd_pins_t pins_raw;
   adcpd_pins_t pins_s;

   assign pins_raw = '{power_down_pin:      i_power_down_pin,
                       clock_source_select: i_clock_source_select,
                       cs_n:                i_cs_n,
                       convert_n:           i_convert_n,
                       ext_sclk:            i_ext_sclk};

   adcpd_sync u_sync (
      .i_clock  (i_clock),
      .i_reset  (i_reset),
      .i_clk_en (i_clk_en),
      .i_pins   (pins_raw),
      .o_pins   (pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State
   adcpd_state_t                  st_q,       st_d;
   logic [`ADCPD_CONV_W-1:0]      conv_cnt_q, conv_cnt_d;
   logic [`ADCPD_RESULT_W-1:0]    shift_q,    shift_d;
   logic [`ADCPD_BITS_W-1:0]      bits_q,     bits_d;
   logic [`ADCPD_DIV_W-1:0]       div_q,      div_d;
   logic [`ADCPD_RECOVERY_W-1:0]  rec_q,      rec_d;
   logic                          sclk_prev_q;
   logic                          cnv_prev_q;
   logic                          busy_n_q,   busy_n_d;
   logic                          data_q,     data_d;
   logic                          dclk_q,     dclk_d;
   logic                          an_on_q,    an_on_d;
   logic                          settled_q,  settled_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding
   wire pd        = pins_s.power_down_pin;
   wire ext_mode  = pins_s.clock_source_select;
   wire cs_act    = ~pins_s.cs_n;
   wire sclk_rise = pins_s.ext_sclk & ~sclk_prev_q;
   wire cnv_fall  = ~pins_s.convert_n & cnv_prev_q;
   wire st_idle   = (st_q == ST_IDLE);
   wire st_conv   = (st_q == ST_CONV);
   wire conv_start = st_idle & cnv_fall & ~pd;
   wire conv_end   = st_conv & (conv_cnt_q == '0);
   wire have_bits  = (bits_q != '0);
   wire int_run    = cs_act & ~ext_mode & have_bits;
   wire div_tick   = (div_q == '0);
   wire int_shift  = int_run & div_tick & dclk_q;
   wire ext_shift  = cs_act & ext_mode & have_bits & sclk_rise;
   wire shift_evt  = int_shift | ext_shift;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   always_comb begin
      st_d       = st_q;
      conv_cnt_d = conv_cnt_q;
      busy_n_d   = busy_n_q;
      case (st_q)
         ST_IDLE: begin
            if (conv_start) begin
               st_d       = ST_CONV;
               conv_cnt_d = `ADCPD_CONV_W'(`ADCPD_CONV_CYCLES - 1);
               busy_n_d   = 1'b0;
            end
         end
         ST_CONV: begin
            if (conv_end) begin
               st_d     = ST_IDLE;
               busy_n_d = 1'b1;
            end else begin
               conv_cnt_d = conv_cnt_q - 1'b1;
            end
         end
         default: begin
            st_d     = ST_IDLE;
            busy_n_d = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result shift register and serial output
   always_comb begin
      shift_d = shift_q;
      bits_d  = bits_q;
      if (conv_end) begin
         shift_d = i_sample_data;
         bits_d  = `ADCPD_BITS_W'(`ADCPD_RESULT_W);
      end else if (shift_evt) begin
         shift_d = {shift_q[`ADCPD_RESULT_W-2:0], 1'b0};
         bits_d  = bits_q - 1'b1;
      end
   end

   assign data_d = cs_act & have_bits & shift_d[`ADCPD_RESULT_W-1];

   ////////////////////////////////////////////////////////////////////////////
   // Internal serial clock, master mode only
   always_comb begin
      div_d  = `ADCPD_DIV_W'(`ADCPD_SCLK_HALF - 1);
      dclk_d = 1'b0;
      if (int_run) begin
         dclk_d = dclk_q;
         div_d  = div_q - 1'b1;
         if (div_tick) begin
            dclk_d = ~dclk_q;
            div_d  = `ADCPD_DIV_W'(`ADCPD_SCLK_HALF - 1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-down and reference recovery
   assign an_on_d   = ~pd;
   assign rec_d     = pd ? '0 : (settled_q ? rec_q : rec_q + 1'b1);
   assign settled_d = ~pd & (settled_q | (rec_q == `ADCPD_RECOVERY_W'(RECOVERY_CYCLES - 1)));

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         st_q        <= ST_IDLE;
         conv_cnt_q  <= '0;
         shift_q     <= `ADCPD_RESULT_RESET;
         bits_q      <= '0;
         div_q       <= '0;
         rec_q       <= '0;
         sclk_prev_q <= 1'b0;
         cnv_prev_q  <= 1'b0;
         busy_n_q    <= 1'b1;
         data_q      <= 1'b0;
         dclk_q      <= 1'b0;
         an_on_q     <= 1'b0;
         settled_q   <= 1'b0;
      end else if (i_clk_en) begin
         st_q        <= st_d;
         conv_cnt_q  <= conv_cnt_d;
         shift_q     <= shift_d;
         bits_q      <= bits_d;
         div_q       <= div_d;
         rec_q       <= rec_d;
         sclk_prev_q <= pins_s.ext_sclk;
         cnv_prev_q  <= pins_s.convert_n;
         busy_n_q    <= busy_n_d;
         data_q      <= data_d;
         dclk_q      <= dclk_d;
         an_on_q     <= an_on_d;
         settled_q   <= settled_d;
      end
   end

   assign o_busy_n      = busy_n_q;
   assign o_data        = data_q;
   assign o_data_clk    = dclk_q;
   assign o_analog_on   = an_on_q;
   assign o_ref_settled = settled_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   a_pd_analog_off: assert property (i_clk_en && pd |=> !o_analog_on && !o_ref_settled)
      else $error("Analog still on in power-down");

   a_pd_no_start: assert property (i_clk_en && pd && st_idle |=> st_q == ST_IDLE && o_busy_n)
      else $error("Conversion started in power-down");

   a_pd_keeps_res: assert property (i_clk_en && pd && st_idle && !shift_evt |=> $stable(shift_q) && $stable(bits_q))
      else $error("Result lost in power-down");

   a_conv_busy: assert property (i_clk_en && conv_start |=> !o_busy_n && st_q == ST_CONV)
      else $error("Convert pulse not taken");

   a_conv_done: assert property (i_clk_en && conv_end |=> o_busy_n && bits_q == `ADCPD_BITS_W'(`ADCPD_RESULT_W))
      else $error("Result not loaded at end of conversion");

   a_ext_no_clk: assert property (i_clk_en && ext_mode |=> !o_data_clk)
      else $error("Clock driven in external mode");

   a_int_clk_tog: assert property (i_clk_en && int_run && div_tick |=> o_data_clk != $past(o_data_clk))
      else $error("Internal clock did not toggle");

   a_ext_shift_cnt: assert property (i_clk_en && ext_shift && !conv_end |=> bits_q == $past(bits_q) - 1'b1)
      else $error("External clock edge not shifted");

   a_cs_quiet: assert property (i_clk_en && !cs_act |=> !o_data && !o_data_clk)
      else $error("Output active while deselected");

   c_conv: cover property (i_clk_en && conv_start);
   c_read_all: cover property (i_clk_en && shift_evt && bits_q == `ADCPD_BITS_W'(1));
   c_pd_read: cover property (i_clk_en && pd && shift_evt);

endmodule

/* File: core/adcpd_params.svh */
`ifndef ADCPD_PARAMS_SVH
`define ADCPD_PARAMS_SVH

// Clock period, in nanoseconds
`define ADCPD_CLK_PERIOD_NS   25

// Power-up recovery of the reference buffer, in microseconds and cycles
`define ADCPD_RECOVERY_US     1000
`define ADCPD_RECOVERY_CYCLES ((`ADCPD_RECOVERY_US * 1000 + `ADCPD_CLK_PERIOD_NS - 1) / `ADCPD_CLK_PERIOD_NS)
`define ADCPD_RECOVERY_W      16

// Conversion time, in nanoseconds and cycles
`define ADCPD_CONV_TIME_NS    4000
`define ADCPD_CONV_CYCLES     ((`ADCPD_CONV_TIME_NS + `ADCPD_CLK_PERIOD_NS - 1) / `ADCPD_CLK_PERIOD_NS)
`define ADCPD_CONV_W          8

// Internal serial clock: half period in system cycles
`define ADCPD_SCLK_HALF       2
`define ADCPD_DIV_W           2

// Result word
`define ADCPD_RESULT_W        16
`define ADCPD_BITS_W          5
`define ADCPD_RESULT_RESET    16'h0000

`endif

/* File: core/adcpd_pkg.sv */
package adcpd_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } adcpd_state_t;

   typedef struct packed {
      logic power_down_pin;
      logic clock_source_select;
      logic cs_n;
      logic convert_n;
      logic ext_sclk;
   } adcpd_pins_t;

endpackage

/* File: core/adcpd_sync.sv */
`timescale 1ns/10ps

module adcpd_sync
   import adcpd_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_clk_en,
   input  wire adcpd_pins_t i_pins,
   output adcpd_pins_t      o_pins
);

   localparam int W = $bits(adcpd_pins_t);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   ////////////////////////////////////////////////////////////////////////////
   // Two flip-flops per pin
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge i_clock or posedge i_reset) begin
            if (i_reset) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else if (i_clk_en) begin
               meta_q[g] <= i_pins[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign o_pins = adcpd_pins_t'(sync_q);

endmodule

/* File: sim/adcpd_host.sv */
`timescale 1ns/10ps
module adcpd_host
(
   input  wire logic i_clock,
   input  wire logic i_busy_n,
   input  wire logic i_data,
   input  wire logic i_data_clk,
   output logic      o_convert_n,
   output logic      o_cs_n,
   output logic      o_ext_sclk
);
   logic receive_frame_sync = 1'b0;
   initial begin
      o_convert_n = 1'b1;
      o_cs_n      = 1'b1;
      o_ext_sclk  = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   // Timer-driven convert pulse, then wait for busy to rise
   task automatic convert(output logic saw_low);
      int n;
      o_convert_n = 1'b0;
      tick(3);
      o_convert_n = 1'b1;
      n = 0;
      while (i_busy_n !== 1'b0 && n < 10) begin
         tick(1);
         n++;
      end
      saw_low = (i_busy_n === 1'b0);
      n = 0;
      while (i_busy_n !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
   endtask
   // Clock driven by host, sampled just before each rising edge, MSB first
   task automatic read_ext(output logic [15:0] w, output logic tail);
      o_cs_n = 1'b0;
      tick(8);
      for (int i = 15; i >= 0; i--) begin
         w[i] = i_data;
         o_ext_sclk = 1'b1;
         tick(4);
         o_ext_sclk = 1'b0;
         tick(4);
      end
      tail = i_data;
      o_cs_n = 1'b1;
      tick(4);
   endtask
   // Clock pulses while deselected must move nothing
   task automatic desel_clocks(output logic seen);
      seen = 1'b0;
      for (int i = 0; i < 4; i++) begin
         o_ext_sclk = 1'b1;
         tick(4);
         seen |= i_data;
         o_ext_sclk = 1'b0;
         tick(4);
      end
   endtask
   // Device drives the clock; sample data on its rising edge
   task automatic read_int(output logic [15:0] w, output logic tail);
      int n;
      for (int i = 15; i >= 0; i--) begin
         n = 0;
         while (i_data_clk !== 1'b1 && n < 400) begin
            tick(1);
            n++;
         end
         w[i] = i_data & receive_frame_sync;
         while (i_data_clk !== 1'b0 && n < 420) begin
            tick(1);
            n++;
         end
      end
      tick(6);
      tail = i_data;
   endtask
   // Framing resync against the discontinuous device clock
   task automatic sync_int();
      logic s;
      receive_frame_sync = 1'b0;
      o_cs_n = 1'b0;
      convert(s);
      tick(80);
      o_cs_n = 1'b1;
      tick(170);
      receive_frame_sync = 1'b1;
      o_cs_n = 1'b0;
   endtask
endmodule

/* File: sim/adc_powerdown_and_host_sync_tb.sv */
`timescale 1ns/10ps
module adc_powerdown_and_host_sync_tb;
   logic        i_clock = 1'b0;
   logic        i_reset;
   logic        i_clk_en;
   logic        i_power_down_pin;
   logic        i_clock_source_select;
   logic [15:0] i_sample_data;
   wire logic   cvt_n, cs_n, sclk, o_busy_n, o_data, o_data_clk, o_analog_on, o_ref_settled;
   int          bad_count = 0;
   int          n_compared = 0;
   logic [15:0] w;
   logic        t, s;
   always #12.5 i_clock = ~i_clock;
   adcpd_ctrl #(.RECOVERY_CYCLES(20)) dut (
      .i_clock(i_clock), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_power_down_pin(i_power_down_pin),
      .i_clock_source_select(i_clock_source_select), .i_cs_n(cs_n), .i_convert_n(cvt_n),
      .i_ext_sclk(sclk), .i_sample_data(i_sample_data), .o_busy_n(o_busy_n), .o_data(o_data),
      .o_data_clk(o_data_clk), .o_analog_on(o_analog_on), .o_ref_settled(o_ref_settled));
   adcpd_host host (
      .i_clock(i_clock), .i_busy_n(o_busy_n), .i_data(o_data), .i_data_clk(o_data_clk),
      .o_convert_n(cvt_n), .o_cs_n(cs_n), .o_ext_sclk(sclk));
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ext();
      i_sample_data = 16'ha5c3;
      host.convert(s);
      check("busy_low", 16'h0001, s);
      host.read_ext(w, t);
      check("ext_word", 16'ha5c3, w);
      check("ext_tail", 16'h0000, t);
   endtask
   task automatic t_desel();
      i_sample_data = 16'h3c96;
      host.convert(s);
      host.desel_clocks(s);
      check("desel_data", 16'h0000, s);
      host.read_ext(w, t);
      check("desel_word", 16'h3c96, w);
   endtask
   task automatic t_hold();
      i_sample_data = 16'h5a3c;
      fork
         host.convert(s);
         begin
            host.tick(50);
            i_clk_en = 1'b0;
            host.tick(100);
            i_clk_en = 1'b1;
            host.tick(30);
            check("hold_busy", 16'h0000, o_busy_n);
         end
      join
      check("hold_start", 16'h0001, s);
      host.read_ext(w, t);
      check("hold_word", 16'h5a3c, w);
   endtask
   task automatic t_pd();
      i_sample_data = 16'h8001;
      host.convert(s);
      i_power_down_pin = 1'b1;
      host.tick(6);
      check("analog_off", 16'h0000, o_analog_on);
      i_sample_data = 16'h7ffe;
      host.convert(s);
      check("pd_refused", 16'h0000, s);
      host.read_ext(w, t);
      check("pd_word", 16'h8001, w);
      host.read_ext(w, t);
      check("pd_empty", 16'h0000, w);
      i_power_down_pin = 1'b0;
      host.tick(5);
      check("ref_early", 16'h0000, o_ref_settled);
      host.tick(30);
      check("ref_late", 16'h0001, o_ref_settled);
      check("analog_on", 16'h0001, o_analog_on);
   endtask
   task automatic t_int();
      i_clock_source_select = 1'b0;
      host.tick(4);
      host.sync_int();
      i_sample_data = 16'hc35a;
      fork
         host.convert(s);
         host.read_int(w, t);
      join
      check("int_word", 16'hc35a, w);
      check("int_tail", 16'h0000, t);
      check("int_clk_idle", 16'h0000, o_data_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_reset = 1'b1;
      i_clk_en = 1'b1;
      i_power_down_pin = 1'b0;
      i_clock_source_select = 1'b1;
      i_sample_data = 16'h0000;
      repeat (4) @(posedge i_clock);
      check("rst_busy_n", 16'h0001, o_busy_n);
      check("rst_data", 16'h0000, o_data);
      #1 i_reset = 1'b0;
      host.tick(6);
      t_ext();
      t_desel();
      t_hold();
      t_pd();
      t_int();
      stop_test();
   end
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule
